// file: shared/tfd_defs.svh
// Register offsets, field positions and reset values of the timer flag block
`ifndef TFD_DEFS_SVH
`define TFD_DEFS_SVH

// Byte addresses on the register bus
`define TFD_OFS_DEAD_TIME 8'h24
`define TFD_OFS_FLAGS 8'h38
`define TFD_OFS_MASK 8'h3c

// Bit positions shared by the flag and mask registers
`define TFD_BIT_MATCH_D 7
`define TFD_BIT_MATCH_A 6
`define TFD_BIT_MATCH_B 5
`define TFD_BIT_OVF 2
`define TFD_FLAG_IMPL 8'he4

// Dead-time fields
`define TFD_DT_TRUE_MSB 7
`define TFD_DT_TRUE_LSB 4
`define TFD_DT_INV_MSB 3
`define TFD_DT_INV_LSB 0

// Reset values
`define TFD_RST_DEAD_TIME 8'h00
`define TFD_RST_FLAGS 8'h00
`define TFD_RST_MASK 8'h00

// Bus responses
`define TFD_RESP_OKAY 2'h0
`define TFD_RESP_SLVERR 2'h2

`endif

// file: shared/tfd_pkg.sv
// Types shared by the timer flag and dead-time logic
`default_nettype none
package tfd_pkg;
	// Counter operating modes
	typedef enum logic [1:0] {
		TFD_MODE_NORMAL = 2'h0,
		TFD_MODE_FAST_PWM = 2'h1,
		TFD_MODE_PFC_PWM = 2'h3
	} tfd_mode_t;

	// Dead-time generator states, Gray coded around the cycle
	typedef enum logic [1:0] {
		TFD_DT_LOW = 2'h0,
		TFD_DT_WAIT_HI = 2'h1,
		TFD_DT_HIGH = 2'h3,
		TFD_DT_WAIT_LO = 2'h2
	} tfd_dt_state_t;

	// Register select from the bus address
	typedef enum logic [1:0] {
		TFD_REG_NONE = 2'h0,
		TFD_REG_DEAD_TIME = 2'h1,
		TFD_REG_FLAGS = 2'h2,
		TFD_REG_MASK = 2'h3
	} tfd_reg_t;
endpackage
`default_nettype wire

// file: src/tfd_deadtime.sv
// Dead-time generator for one complementary output pair
`timescale 1ns/100ps
`default_nettype none
module tfd_deadtime (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Prescaled timer clock enable
	input wire logic psc_tick,
	// Raw waveform and delays in prescaled ticks
	input wire logic raw_in,
	input wire logic [3:0] dt_true,
	input wire logic [3:0] dt_inv,
	// Complementary outputs
	output logic out_true,
	output logic out_inv
);
	import tfd_pkg::*;

	tfd_dt_state_t state_q;
	logic [3:0] cnt_q;

	// Each rising edge waits its own delay; falling edges act at once so both sides never overlap
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= TFD_DT_LOW;
			cnt_q <= 4'h0;
		end else begin
			unique case (state_q)
				TFD_DT_LOW: begin
					cnt_q <= 4'h0;
					if (raw_in) begin
						state_q <= TFD_DT_WAIT_HI;
					end
				end
				TFD_DT_WAIT_HI: begin
					if (!raw_in) begin
						state_q <= TFD_DT_WAIT_LO;
						cnt_q <= 4'h0;
					end else if (cnt_q == dt_true) begin
						state_q <= TFD_DT_HIGH;
					end else if (psc_tick) begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
				TFD_DT_HIGH: begin
					cnt_q <= 4'h0;
					if (!raw_in) begin
						state_q <= TFD_DT_WAIT_LO;
					end
				end
				TFD_DT_WAIT_LO: begin
					if (raw_in) begin
						state_q <= TFD_DT_WAIT_HI;
						cnt_q <= 4'h0;
					end else if (cnt_q == dt_inv) begin
						state_q <= TFD_DT_LOW;
					end else if (psc_tick) begin
						cnt_q <= cnt_q + 4'h1;
					end
				end
			endcase
		end
	end

	// Outputs decode straight from the state register
	assign out_true = (state_q == TFD_DT_HIGH);
	assign out_inv = (state_q == TFD_DT_LOW);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_never_overlap: assert property (!(out_true && out_inv))
		else $error("true and complementary outputs high together");
	a_true_waits: assert property ($rose(out_true) |-> $past(cnt_q) == dt_true)
		else $error("true output rose before its dead time elapsed");
	a_inv_waits: assert property ($rose(out_inv) |-> $past(cnt_q) == dt_inv)
		else $error("complementary output rose before its dead time elapsed");
endmodule
`default_nettype wire

// file: src/tfd_top.sv
// Timer interrupt flags, interrupt enables and dead-time setting with AXI4-Lite access
// Summary of operation
// - Request match D vector when its enable, global enable and flag are set.
// - Request match A vector when its enable, global enable and flag are set.
// - Request match B vector when its enable, global enable and flag are set.
// - Request overflow vector when its enable, global enable and flag are set.
// - Match D sets its flag; vector entry or delayed write-one clears it.
// - Match A sets its flag; vector entry or delayed write-one clears it.
// - Match B sets its flag; vector entry or delayed write-one clears it.
// - Normal and fast PWM: overflow flag sets when counter wraps top to bottom.
// - Phase and frequency correct mode: overflow flag sets when bottom is loaded.
// - Overflow flag clears on vector entry or one cycle after write-one.
// - One dead-time value serves all channels; high nibble true, low inverted.
// - Each delay equals field value times prescaled clock period, zero to fifteen.
// - Only counting into the compare value matches; software loads never do.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "tfd_defs.svh"
module tfd_top #(
	parameter int CNT_W = 10,
	parameter int CHANNELS = 3
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// AXI4-Lite write address and data
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Counter core status
	input wire logic [CNT_W-1:0] CNT_VALUE,
	input wire logic CNT_STEP,
	input wire logic CNT_SW_LOAD,
	input wire logic CNT_WRAP,
	input wire logic CNT_BOTTOM,
	input wire tfd_pkg::tfd_mode_t CNT_MODE,
	// Compare values
	input wire logic [CNT_W-1:0] CMP_A,
	input wire logic [CNT_W-1:0] CMP_B,
	input wire logic [CNT_W-1:0] CMP_D,
	// CPU interrupt interface, vectors ordered {D, A, B, overflow}
	input wire logic CPU_STATUS_IEN,
	input wire logic [3:0] VEC_ACK,
	output logic [3:0] IRQ_REQ,
	output logic IRQ,
	// Dead-time generator
	input wire logic PSC_TICK,
	input wire logic [CHANNELS-1:0] PWM_RAW,
	output logic [CHANNELS-1:0] PWM_CHANNEL_OUTPUT,
	output logic [CHANNELS-1:0] PWM_CHANNEL_OUTPUT_INV
);
	import tfd_pkg::*;

	// Spread a {D, A, B, overflow} vector onto the register bit layout
	function automatic logic [7:0] to_layout(input logic [3:0] v);
		logic [7:0] r;
		r = 8'h00;
		r[`TFD_BIT_MATCH_D] = v[3];
		r[`TFD_BIT_MATCH_A] = v[2];
		r[`TFD_BIT_MATCH_B] = v[1];
		r[`TFD_BIT_OVF] = v[0];
		return r;
	endfunction

	// Gather the register bit layout back into a {D, A, B, overflow} vector
	function automatic logic [3:0] from_layout(input logic [7:0] r);
		return {r[`TFD_BIT_MATCH_D], r[`TFD_BIT_MATCH_A], r[`TFD_BIT_MATCH_B], r[`TFD_BIT_OVF]};
	endfunction

	// Word address decode shared by the read and write paths
	function automatic tfd_reg_t reg_sel(input logic [7:0] addr);
		tfd_reg_t s;
		s = TFD_REG_NONE;
		if ({addr[7:2], 2'b00} == `TFD_OFS_DEAD_TIME) begin
			s = TFD_REG_DEAD_TIME;
		end else if ({addr[7:2], 2'b00} == `TFD_OFS_FLAGS) begin
			s = TFD_REG_FLAGS;
		end else if ({addr[7:2], 2'b00} == `TFD_OFS_MASK) begin
			s = TFD_REG_MASK;
		end
		return s;
	endfunction

	// Bus side state
	logic aw_held_q;
	logic [7:0] awaddr_q;
	logic w_held_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_fire;
	logic rd_fire;
	logic wr_lane0;
	tfd_reg_t wr_sel;
	tfd_reg_t rd_sel;

	// Block registers
	logic [7:0] dead_time_setting_q;
	logic [7:0] timer_interrupt_mask_q;
	logic [7:0] timer_interrupt_flags_q;
	logic [7:0] clr_pend_q;
	logic [7:0] event_q;
	logic [7:0] event_d;
	logic [7:0] ack_vec;
	logic [3:1] match_ev;
	logic overflow_ev;
	logic counted;

	// Write channels are taken independently, but only while no response is waiting
	assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
	assign S_AXI_WREADY = !w_held_q && !bvalid_q;
	assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
	assign wr_sel = reg_sel(awaddr_q);
	assign wr_lane0 = wstrb_q[0];

	// Capture write address
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			aw_held_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_held_q <= 1'b1;
			awaddr_q <= S_AXI_AWADDR;
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	// Capture write data
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			w_held_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_held_q <= 1'b1;
			wdata_q <= S_AXI_WDATA;
			wstrb_q <= S_AXI_WSTRB;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	// Write response, unmapped addresses answer with a slave error
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			bvalid_q <= 1'b0;
			bresp_q <= `TFD_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_sel == TFD_REG_NONE) ? `TFD_RESP_SLVERR : `TFD_RESP_OKAY;
		end else if (S_AXI_BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;

	// Read path, one outstanding read
	assign S_AXI_ARREADY = !rvalid_q;
	assign rd_fire = S_AXI_ARVALID && !rvalid_q;
	assign rd_sel = reg_sel(S_AXI_ARADDR);

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `TFD_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rresp_q <= `TFD_RESP_OKAY;
			unique case (rd_sel)
				TFD_REG_DEAD_TIME: rdata_q <= {24'h000000, dead_time_setting_q};
				TFD_REG_FLAGS: rdata_q <= {24'h000000, timer_interrupt_flags_q};
				TFD_REG_MASK: rdata_q <= {24'h000000, timer_interrupt_mask_q};
				TFD_REG_NONE: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= `TFD_RESP_SLVERR;
				end
			endcase
		end else if (S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;

	// Plain read/write configuration registers, only byte lane 0 carries data
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			dead_time_setting_q <= `TFD_RST_DEAD_TIME;
			timer_interrupt_mask_q <= `TFD_RST_MASK;
		end else if (wr_fire && wr_lane0) begin
			if (wr_sel == TFD_REG_DEAD_TIME) begin
				dead_time_setting_q <= wdata_q[7:0];
			end
			if (wr_sel == TFD_REG_MASK) begin
				timer_interrupt_mask_q <= wdata_q[7:0] & `TFD_FLAG_IMPL;
			end
		end
	end

	// Write-one clears wait a synchronisation cycle; zero bits request nothing
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			clr_pend_q <= 8'h00;
		end else if (wr_fire && wr_lane0 && wr_sel == TFD_REG_FLAGS) begin
			clr_pend_q <= wdata_q[7:0] & `TFD_FLAG_IMPL;
		end else begin
			clr_pend_q <= 8'h00;
		end
	end

	// Only a counting step can match; a software load of the counter is excluded
	assign counted = CNT_STEP && !CNT_SW_LOAD;
	assign match_ev[3] = counted && (CNT_VALUE == CMP_D);
	assign match_ev[2] = counted && (CNT_VALUE == CMP_A);
	assign match_ev[1] = counted && (CNT_VALUE == CMP_B);

	// Overflow source depends on the counting mode
	always_comb begin
		unique case (CNT_MODE)
			TFD_MODE_NORMAL: overflow_ev = CNT_WRAP;
			TFD_MODE_FAST_PWM: overflow_ev = CNT_WRAP;
			TFD_MODE_PFC_PWM: overflow_ev = CNT_BOTTOM;
			default: overflow_ev = 1'b0;
		endcase
	end

	assign event_d = to_layout({match_ev[3:1], overflow_ev});
	assign ack_vec = to_layout(VEC_ACK);

	// Events pass one synchronisation stage before reaching the flags
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			event_q <= 8'h00;
		end else begin
			event_q <= event_d;
		end
	end

	// Sticky flags: a new event wins over a clear arriving in the same cycle
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			timer_interrupt_flags_q <= `TFD_RST_FLAGS;
		end else begin
			timer_interrupt_flags_q <= ((timer_interrupt_flags_q & ~clr_pend_q & ~ack_vec)
				| event_q) & `TFD_FLAG_IMPL;
		end
	end

	// Per-vector requests need flag, enable and the CPU global enable
	assign IRQ_REQ = from_layout(timer_interrupt_flags_q & timer_interrupt_mask_q)
		& {4{CPU_STATUS_IEN}};
	// Summary line ignores the global enable so a wake-up path still sees pending work
	assign IRQ = |(timer_interrupt_flags_q & timer_interrupt_mask_q);

	// One dead-time setting fans out to every channel
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_dt
			tfd_deadtime u_dt (
				.clk(MCLK),
				.rst(SYS_RST),
				.psc_tick(PSC_TICK),
				.raw_in(PWM_RAW[ch]),
				.dt_true(dead_time_setting_q[`TFD_DT_TRUE_MSB:`TFD_DT_TRUE_LSB]),
				.dt_inv(dead_time_setting_q[`TFD_DT_INV_MSB:`TFD_DT_INV_LSB]),
				.out_true(PWM_CHANNEL_OUTPUT[ch]),
				.out_inv(PWM_CHANNEL_OUTPUT_INV[ch])
			);
		end
	endgenerate

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);

	// Flag rises while enabled and globally allowed
	sequence s_rise_d;
		$rose(timer_interrupt_flags_q[`TFD_BIT_MATCH_D]);
	endsequence
	sequence s_rise_a;
		$rose(timer_interrupt_flags_q[`TFD_BIT_MATCH_A]);
	endsequence
	sequence s_rise_b;
		$rose(timer_interrupt_flags_q[`TFD_BIT_MATCH_B]);
	endsequence
	sequence s_rise_ovf;
		$rose(timer_interrupt_flags_q[`TFD_BIT_OVF]);
	endsequence

	a_irq_req_d: assert property (s_rise_d ##0 timer_interrupt_mask_q[`TFD_BIT_MATCH_D]
		&& CPU_STATUS_IEN |-> IRQ_REQ[3])
		else $error("match D request missing");
	a_irq_req_a: assert property (s_rise_a ##0 timer_interrupt_mask_q[`TFD_BIT_MATCH_A]
		&& CPU_STATUS_IEN |-> IRQ_REQ[2])
		else $error("match A request missing");
	a_irq_req_b: assert property (s_rise_b ##0 timer_interrupt_mask_q[`TFD_BIT_MATCH_B]
		&& CPU_STATUS_IEN |-> IRQ_REQ[1])
		else $error("match B request missing");
	a_irq_req_ovf: assert property (s_rise_ovf ##0 timer_interrupt_mask_q[`TFD_BIT_OVF]
		&& CPU_STATUS_IEN |-> IRQ_REQ[0])
		else $error("overflow request missing");
	a_irq_gated: assert property (!CPU_STATUS_IEN |-> IRQ_REQ == 4'h0)
		else $error("request raised without global enable");

	// A counted match shows in the flag two edges later
	sequence s_match_d;
		CNT_STEP && !CNT_SW_LOAD && CNT_VALUE == CMP_D;
	endsequence
	a_match_d_flag: assert property (s_match_d |-> ##2 timer_interrupt_flags_q[`TFD_BIT_MATCH_D])
		else $error("match D flag not set two cycles after match");
	a_match_a_flag: assert property (counted && CNT_VALUE == CMP_A
		|-> ##2 timer_interrupt_flags_q[`TFD_BIT_MATCH_A])
		else $error("match A flag not set two cycles after match");
	a_match_b_flag: assert property (counted && CNT_VALUE == CMP_B
		|-> ##2 timer_interrupt_flags_q[`TFD_BIT_MATCH_B])
		else $error("match B flag not set two cycles after match");

	a_ovf_wrap: assert property (CNT_MODE inside {TFD_MODE_NORMAL, TFD_MODE_FAST_PWM}
		&& CNT_WRAP |-> ##2 timer_interrupt_flags_q[`TFD_BIT_OVF])
		else $error("overflow flag not set after wrap");
	a_ovf_bottom: assert property (CNT_MODE == TFD_MODE_PFC_PWM && CNT_BOTTOM
		|-> ##2 timer_interrupt_flags_q[`TFD_BIT_OVF])
		else $error("overflow flag not set at bottom load");

	// Write-one to overflow clears it after the synchronisation cycle unless re-set
	sequence s_w1c_ovf;
		wr_fire && wr_lane0 && wr_sel == TFD_REG_FLAGS && wdata_q[`TFD_BIT_OVF]
		##1 !event_q[`TFD_BIT_OVF];
	endsequence
	a_w1c_ovf: assert property (s_w1c_ovf |=> !timer_interrupt_flags_q[`TFD_BIT_OVF])
		else $error("overflow flag not cleared by write-one");
	a_ack_clear: assert property (VEC_ACK[3] && !event_q[`TFD_BIT_MATCH_D]
		|=> !timer_interrupt_flags_q[`TFD_BIT_MATCH_D])
		else $error("match D flag survived vector entry");

	a_sw_no_match: assert property (CNT_SW_LOAD |=> !event_q[`TFD_BIT_MATCH_D]
		&& !event_q[`TFD_BIT_MATCH_A] && !event_q[`TFD_BIT_MATCH_B])
		else $error("software load produced a match");

	// Zero written to a set flag keeps it when no vector entry intervenes
	sequence s_w0_d;
		wr_fire && wr_lane0 && wr_sel == TFD_REG_FLAGS && !wdata_q[`TFD_BIT_MATCH_D]
		&& timer_interrupt_flags_q[`TFD_BIT_MATCH_D] && !VEC_ACK[3] ##1 !VEC_ACK[3];
	endsequence
	a_w0_keeps: assert property (s_w0_d |=> timer_interrupt_flags_q[`TFD_BIT_MATCH_D])
		else $error("flag lost after writing zero");
endmodule
`default_nettype wire

// file: dv/tb_tfd_top.sv
// Self-checking bench for the timer flag, interrupt enable and dead-time block
`timescale 1ns/100ps
`default_nettype none
`include "tfd_defs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_tfd_top;
	import tfd_pkg::*;
	logic MCLK, SYS_RST;
	logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
	logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
	logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
	logic [9:0] CNT_VALUE, CMP_A, CMP_B, CMP_D;
	logic CNT_STEP, CNT_SW_LOAD, CNT_WRAP, CNT_BOTTOM, CPU_STATUS_IEN, IRQ, PSC_TICK;
	tfd_mode_t CNT_MODE;
	logic [3:0] VEC_ACK, IRQ_REQ;
	logic [2:0] PWM_RAW, PWM_CHANNEL_OUTPUT, PWM_CHANNEL_OUTPUT_INV;
	int errors = 0;
	int num_checks = 0;
	logic [1:0] r;
	logic [31:0] rd;
	logic [9:0] cmpv [3] = '{10'h3ff, 10'h011, 10'h022};
	int fb [3] = '{7, 6, 5};

	tfd_top i_tfd_top (.MCLK(MCLK), .SYS_RST(SYS_RST),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .CNT_VALUE(CNT_VALUE),
		.CNT_STEP(CNT_STEP), .CNT_SW_LOAD(CNT_SW_LOAD), .CNT_WRAP(CNT_WRAP),
		.CNT_BOTTOM(CNT_BOTTOM), .CNT_MODE(CNT_MODE), .CMP_A(CMP_A), .CMP_B(CMP_B),
		.CMP_D(CMP_D), .CPU_STATUS_IEN(CPU_STATUS_IEN), .VEC_ACK(VEC_ACK), .IRQ_REQ(IRQ_REQ),
		.IRQ(IRQ), .PSC_TICK(PSC_TICK), .PWM_RAW(PWM_RAW),
		.PWM_CHANNEL_OUTPUT(PWM_CHANNEL_OUTPUT), .PWM_CHANNEL_OUTPUT_INV(PWM_CHANNEL_OUTPUT_INV));

	// 200 MHz clock
	initial begin
		MCLK = 1'b0;
		forever #2.5 MCLK = ~MCLK;
	end

	// Readies are sampled at the falling edge, where flop outputs are settled
	// Response readies are driven high by each call and never lowered, so they stay high between transfers
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
		logic aw_hs, w_hs, done;
		done = 1'b0;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		while (!done) begin
			@(negedge MCLK);
			aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
			w_hs = S_AXI_WVALID && S_AXI_WREADY;
			done = S_AXI_BVALID;
			rsp = S_AXI_BRESP;
			@(posedge MCLK);
			if (aw_hs) S_AXI_AWVALID <= 1'b0;
			if (w_hs) S_AXI_WVALID <= 1'b0;
		end
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
		logic ar_hs, done;
		done = 1'b0;
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		while (!done) begin
			@(negedge MCLK);
			ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
			done = S_AXI_RVALID;
			d = S_AXI_RDATA;
			rsp = S_AXI_RRESP;
			@(posedge MCLK);
			if (ar_hs) S_AXI_ARVALID <= 1'b0;
		end
	endtask

	// Register read compared with an expected word and an OKAY answer
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] rsp;
		axr(a, d, rsp);
		`CHK(d, e)
		`CHK(rsp, `TFD_RESP_OKAY)
	endtask

	// One counter event; the flag shows two edges after the sampling edge
	task automatic cnt_ev(input logic [9:0] v, input logic sw, input logic wr, input logic bt);
		CNT_VALUE <= v;
		CNT_STEP <= 1'b1;
		CNT_SW_LOAD <= sw;
		CNT_WRAP <= wr;
		CNT_BOTTOM <= bt;
		@(posedge MCLK);
		CNT_VALUE <= 10'h200;
		CNT_STEP <= 1'b0;
		CNT_SW_LOAD <= 1'b0;
		CNT_WRAP <= 1'b0;
		CNT_BOTTOM <= 1'b0;
		repeat (2) @(posedge MCLK);
	endtask

	task automatic chk_irq(input logic [3:0] e, input logic ei);
		@(negedge MCLK);
		`CHK(IRQ_REQ, e)
		`CHK(IRQ, ei)
		@(posedge MCLK);
	endtask

	task automatic ack(input logic [3:0] v);
		VEC_ACK <= v;
		@(posedge MCLK);
		VEC_ACK <= 4'h0;
		@(posedge MCLK);
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Complementary outputs may never be high together
	always @(negedge MCLK) begin
		if (!SYS_RST) `CHK(PWM_CHANNEL_OUTPUT & PWM_CHANNEL_OUTPUT_INV, 3'h0)
	end

	// Watchdog well beyond the expected run of about two hundred cycles
	initial begin
		repeat (20000) @(posedge MCLK);
		errors++;
		close_out();
	end

	initial begin
		SYS_RST = 1'b1;
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
		S_AXI_WSTRB = 4'hf;
		{CNT_VALUE, CNT_STEP, CNT_SW_LOAD, CNT_WRAP, CNT_BOTTOM} = '0;
		CNT_MODE = TFD_MODE_NORMAL;
		CMP_D = cmpv[0];
		CMP_A = cmpv[1];
		CMP_B = cmpv[2];
		{CPU_STATUS_IEN, VEC_ACK, PSC_TICK, PWM_RAW} = '0;
		repeat (10) @(posedge MCLK);
		SYS_RST <= 1'b0;
		@(posedge MCLK);
		// Reset values, unmapped places, read-write storage
		chk_reg(`TFD_OFS_DEAD_TIME, 32'h0);
		chk_reg(`TFD_OFS_FLAGS, 32'h0);
		chk_reg(`TFD_OFS_MASK, 32'h0);
		axw(8'h10, 32'hff, r);
		`CHK(r, `TFD_RESP_SLVERR)
		axr(8'h10, rd, r);
		`CHK(r, `TFD_RESP_SLVERR)
		`CHK(rd, 32'h0)
		axw(`TFD_OFS_DEAD_TIME, 32'ha5, r);
		`CHK(r, `TFD_RESP_OKAY)
		chk_reg(`TFD_OFS_DEAD_TIME, 32'ha5);
		// Byte lane 0 disabled: the write is answered but ignored
		S_AXI_WSTRB <= 4'he;
		axw(`TFD_OFS_DEAD_TIME, 32'h5a, r);
		`CHK(r, `TFD_RESP_OKAY)
		chk_reg(`TFD_OFS_DEAD_TIME, 32'ha5);
		S_AXI_WSTRB <= 4'hf;
		axw(`TFD_OFS_MASK, 32'hff, r);
		chk_reg(`TFD_OFS_MASK, 32'he4);
		CPU_STATUS_IEN <= 1'b1;
		// Each compare channel: set, write-zero kept, write-one cleared
		for (int i = 0; i < 3; i++) begin
			cnt_ev(cmpv[i], 1'b0, 1'b0, 1'b0);
			chk_irq(4'h8 >> i, 1'b1);
			chk_reg(`TFD_OFS_FLAGS, 32'h1 << fb[i]);
			axw(`TFD_OFS_FLAGS, ~(32'h1 << fb[i]), r);
			chk_reg(`TFD_OFS_FLAGS, 32'h1 << fb[i]);
			axw(`TFD_OFS_FLAGS, 32'h1 << fb[i], r);
			chk_irq(4'h0, 1'b0);
			cnt_ev(cmpv[i], 1'b0, 1'b0, 1'b0);
			ack(4'h8 >> i);
			chk_irq(4'h0, 1'b0);
		end
		// Software load onto the compare value never raises a match
		cnt_ev(cmpv[1], 1'b1, 1'b0, 1'b0);
		chk_reg(`TFD_OFS_FLAGS, 32'h0);
		// Global enable off, then vector entry clears
		CPU_STATUS_IEN <= 1'b0;
		cnt_ev(cmpv[1], 1'b0, 1'b0, 1'b0);
		chk_irq(4'h0, 1'b1);
		ack(4'h4);
		chk_irq(4'h0, 1'b0);
		CPU_STATUS_IEN <= 1'b1;
		// Mask bit off keeps the request quiet although the flag sets
		axw(`TFD_OFS_MASK, 32'ha4, r);
		cnt_ev(cmpv[1], 1'b0, 1'b0, 1'b0);
		chk_irq(4'h0, 1'b0);
		chk_reg(`TFD_OFS_FLAGS, 32'h40);
		axw(`TFD_OFS_FLAGS, 32'h40, r);
		axw(`TFD_OFS_MASK, 32'he4, r);
		// Overflow in normal and fast modes from the wrap
		for (int m = 0; m < 2; m++) begin
			CNT_MODE <= (m == 0) ? TFD_MODE_NORMAL : TFD_MODE_FAST_PWM;
			cnt_ev(10'h000, 1'b0, 1'b1, 1'b0);
			chk_irq(4'h1, 1'b1);
			ack(4'h1);
			chk_irq(4'h0, 1'b0);
		end
		// Overflow in phase and frequency correct mode from the bottom load
		CNT_MODE <= TFD_MODE_PFC_PWM;
		cnt_ev(10'h000, 1'b0, 1'b0, 1'b1);
		chk_irq(4'h1, 1'b1);
		chk_reg(`TFD_OFS_FLAGS, 32'h04);
		axw(`TFD_OFS_FLAGS, 32'h04, r);
		chk_irq(4'h0, 1'b0);
		// A top-to-bottom wrap is no overflow source in this mode
		cnt_ev(10'h000, 1'b0, 1'b1, 1'b0);
		chk_irq(4'h0, 1'b0);
		// Dead time: three ticks before true rises, one before inverted rises
		axw(`TFD_OFS_DEAD_TIME, 32'h31, r);
		PWM_RAW <= 3'h7;
		repeat (12) @(posedge MCLK);
		@(negedge MCLK);
		`CHK(PWM_CHANNEL_OUTPUT, 3'h0)
		`CHK(PWM_CHANNEL_OUTPUT_INV, 3'h0)
		chk_irq(4'h0, 1'b0);
		PSC_TICK <= 1'b1;
		repeat (2) @(posedge MCLK);
		@(negedge MCLK);
		`CHK(PWM_CHANNEL_OUTPUT, 3'h0)
		repeat (8) @(posedge MCLK);
		@(negedge MCLK);
		`CHK(PWM_CHANNEL_OUTPUT, 3'h7)
		@(posedge MCLK);
		PWM_RAW <= 3'h0;
		repeat (8) @(posedge MCLK);
		@(negedge MCLK);
		`CHK(PWM_CHANNEL_OUTPUT, 3'h0)
		`CHK(PWM_CHANNEL_OUTPUT_INV, 3'h7)
		close_out();
	end
endmodule
`default_nettype wire
